// ---- fault_manager_pkg.sv ----
// Constants shared by the motor driver fault supervisor.
// Assumes a 10 MHz core clock and comparator inputs from analog blocks.
`default_nettype none
package fault_manager_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned FET_COUNT = 6;
    // Deglitch and retry times
    localparam int unsigned OC_DEG_FIXED_NS = 600;
    localparam int unsigned OC_DEG_CYCLES =
        (OC_DEG_FIXED_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned REG_DEG_NS = 1000;
    localparam int unsigned REG_DEG_CYCLES = (REG_DEG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RETRY_US = 5000;
    localparam int unsigned RETRY_CYCLES_DEF = RETRY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned STALL_FIXED_MS = 1000;
    localparam int unsigned STALL_CYCLES_DEF = STALL_FIXED_MS * (CLK_HZ / 1000);
    localparam int unsigned STALL_RETRY_MS = 500;
    localparam int unsigned STALL_RETRY_CYCLES_DEF = STALL_RETRY_MS * (CLK_HZ / 1000);
    localparam int unsigned RST_PULSE_MAX_US = 40;
    localparam int unsigned RST_PULSE_MAX_CYCLES = RST_PULSE_MAX_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 24;
    // Overvoltage thresholds in volts
    localparam logic [5:0] OV_FIXED_V = 6'h22;
    localparam logic [5:0] OV_LOW_V = 6'h14;
    localparam logic [5:0] OV_HIGH_V = 6'h20;
    // Response modes for overcurrent and stall
    localparam logic [1:0] MODE_LATCH = 2'h0;
    localparam logic [1:0] MODE_RETRY = 2'h1;
    localparam logic [1:0] MODE_REPORT = 2'h2;
    localparam logic [1:0] MODE_OFF = 2'h3;
    // Register port map (word offsets)
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_CHIP_STATUS = 4'h1;
    localparam logic [3:0] ADDR_FAULT_STATUS = 4'h2;
    localparam logic [3:0] ADDR_CONTROL = 4'h3;
    localparam logic [3:0] ADDR_STALL_TIME = 4'h4;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] STALL_TIME_RESET = 16'h03E8;
    // Config field positions
    localparam int CFG_OV_EN = 0;
    localparam int CFG_OV_SEL = 1;
    localparam int CFG_OC_MODE = 2;
    localparam int CFG_STALL_MODE = 4;
    localparam int CFG_THERMAL_WARNING_REPORT_EN = 6;
    localparam int CFG_OC_DEG = 7;
    localparam int CFG_OC_LVL = 9;
    localparam int CTL_CLEAR = 0;
    typedef enum logic [1:0] {RETRY_IDLE, RETRY_WAIT} retry_type;
    typedef enum logic [1:0] {SLP_HIGH, SLP_LOW_SHORT, SLP_LOW_LONG} sleep_type;
endpackage
`default_nettype wire

// ---- motor_driver_fault_manager.sv ----
// Fault supervisor for a three-phase motor driver: gates the power FETs,
// drives the active-low alarm pin and keeps latched status flags.
// Assumes comparator inputs are asynchronous and software uses a simple strobe port.
// Notes on behaviour
// - overvoltage disables FETs, alarms, latches flags
// - overvoltage recovers alone; flag waits for clear
// - overvoltage needs enable; pin variant fixed 34 V
// - level select picks 20 V or 32 V
// - overcurrent needs deglitch; pin variant fixed, latched
// - level, deglitch and mode come from config
// - mode 00 latches off until clear
// - mode 01 retries after delay, flags stay
// - mode 10 reports only, alarm held until clear
// - mode 11 ignores overcurrent entirely
// - regulator overcurrent retries; flags drop after retry
// - stall when Hall silent; pin variant 1000 ms
// - stall time and mode from config
// - stall mode 00 latches off until clear
// - stall mode 01 retries; flags drop after retry
// - stall mode 10 reports until clear
// - stall mode 11 ignores stall
// - thermal warning sets flags, keeps running
// - warning alarms only when reporting enabled
// - warning flag clears only below trip
// - thermal shutdown stops FETs and pump, always
//
// The strobed register port and the placing of the registers were decided locally.
`default_nettype none
module motor_driver_fault_manager
    import fault_manager_pkg::*;
#(
    parameter bit PIN_VARIANT = 1'b0,
    parameter int unsigned RETRY_CYCLES = RETRY_CYCLES_DEF,
    parameter int unsigned STALL_RETRY_CYCLES = STALL_RETRY_CYCLES_DEF,
    parameter int unsigned STALL_MS_CYCLES = CLK_HZ / 1000
) (
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic [5:0]           supply_volts,
    input  wire logic [FET_COUNT-1:0] fet_over_lvl,
    input  wire logic                 reg_over_current,
    input  wire logic [2:0]           hall_in,
    input  wire logic                 temp_over_warn,
    input  wire logic                 temp_below_hys,
    input  wire logic                 temp_over_shutdown,
    input  wire logic                 sleep_pin_n,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [15:0]               reg_rdata,
    output logic                      alarm_out_n,
    output logic                      fet_enable,
    output logic                      reg_fet_enable,
    output logic                      charge_pump_enable,
    output logic [1:0]                oc_level_sel
);
    // Two-flop synchronisers for all asynchronous inputs
    // The sleep bit resets to its idle high level; a low reset value would
    // look like a short sleep pulse and fire a false clear after reset.
    logic [15:0] sync1, sync2;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1 <= {15'h0000, 1'b1};
            sync2 <= {15'h0000, 1'b1};
        end else begin
            sync1 <= {supply_volts, fet_over_lvl, reg_over_current, temp_over_warn, temp_over_shutdown, sleep_pin_n};
            sync2 <= sync1;
        end
    end
    logic [2:0] hall_s1, hall_s2, hall_prev;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hall_s1 <= '0;
            hall_s2 <= '0;
            hall_prev <= '0;
        end else begin
            hall_s1 <= hall_in;
            hall_s2 <= hall_s1;
            hall_prev <= hall_s2;
        end
    end
    logic hys_s1, hys_s2;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hys_s1 <= 1'b1;
            hys_s2 <= 1'b1;
        end else begin
            hys_s1 <= temp_below_hys;
            hys_s2 <= hys_s1;
        end
    end
    logic [5:0]           volts;
    logic [FET_COUNT-1:0] oc_raw;
    logic                 rg_raw, warn_raw, shut_raw, sleep_s;
    assign {volts, oc_raw, rg_raw, warn_raw, shut_raw, sleep_s} = sync2;

    // Configuration registers
    logic [15:0] config_reg;
    logic [15:0] stall_time;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_reg <= CONFIG_RESET;
            stall_time <= STALL_TIME_RESET;
        end else if (reg_wr && reg_addr == ADDR_CONFIG) begin
            config_reg <= reg_wdata;
        end else if (reg_wr && reg_addr == ADDR_STALL_TIME) begin
            stall_time <= reg_wdata;
        end
    end
    // Pin variant forces fixed settings; register fields other than the overcurrent level ignored there
    logic       ov_en, thermal_warning_report_en;
    logic [1:0] oc_mode, stall_mode, oc_deg_sel;
    logic [5:0] ov_thresh;
    assign ov_en = PIN_VARIANT ? 1'b1 : config_reg[CFG_OV_EN];
    assign ov_thresh = PIN_VARIANT ? OV_FIXED_V :
                       (config_reg[CFG_OV_SEL] ? OV_HIGH_V : OV_LOW_V);
    assign oc_mode = PIN_VARIANT ? MODE_LATCH : config_reg[CFG_OC_MODE +: 2];
    assign stall_mode = PIN_VARIANT ? MODE_LATCH : config_reg[CFG_STALL_MODE +: 2];
    assign thermal_warning_report_en = PIN_VARIANT ? 1'b0 : config_reg[CFG_THERMAL_WARNING_REPORT_EN];
    assign oc_deg_sel = PIN_VARIANT ? 2'h0 : config_reg[CFG_OC_DEG +: 2];

    // Clear command: software strobe or short low pulse on the sleep pin
    // A low period past the window is a real sleep request and clears nothing here
    logic       clear_alarms_cmd, sw_clear, pulse_clear;
    logic [9:0] slp_cnt;
    sleep_type  slp_state;
    assign sw_clear = reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[CTL_CLEAR];
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slp_state <= SLP_HIGH;
            slp_cnt <= '0;
            pulse_clear <= 1'b0;
        end else begin
            pulse_clear <= 1'b0;
            unique case (slp_state)
                SLP_HIGH: begin
                    slp_cnt <= '0;
                    if (!sleep_s) slp_state <= SLP_LOW_SHORT;
                end
                SLP_LOW_SHORT: begin
                    if (sleep_s) begin
                        pulse_clear <= 1'b1;
                        slp_state <= SLP_HIGH;
                    end else if (slp_cnt == 10'(RST_PULSE_MAX_CYCLES - 1)) begin
                        slp_state <= SLP_LOW_LONG;
                    end else begin
                        slp_cnt <= slp_cnt + 10'h001;
                    end
                end
                SLP_LOW_LONG: begin
                    if (sleep_s) slp_state <= SLP_HIGH;
                end
                default: slp_state <= SLP_HIGH;
            endcase
        end
    end
    assign clear_alarms_cmd = sw_clear || pulse_clear;

    // Overcurrent deglitch per FET; the deglitch depends on the selected code
    function automatic logic [CNT_W-1:0] deg_cycles(input logic [1:0] sel);
        deg_cycles = CNT_W'(OC_DEG_CYCLES) << sel;
    endfunction
    logic [CNT_W-1:0] oc_cnt [FET_COUNT];
    logic [FET_COUNT-1:0] oc_event;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < FET_COUNT; i++) oc_cnt[i] <= '0;
            oc_event <= '0;
        end else begin
            for (int i = 0; i < FET_COUNT; i++) begin
                if (!oc_raw[i]) oc_cnt[i] <= '0;
                else if (oc_cnt[i] != deg_cycles(oc_deg_sel)) oc_cnt[i] <= oc_cnt[i] + 1'b1;
                oc_event[i] <= oc_raw[i] && oc_cnt[i] == deg_cycles(oc_deg_sel);
            end
        end
    end
    assign oc_level_sel = config_reg[CFG_OC_LVL +: 2];

    // Overcurrent response; disabled mode ignores the event entirely
    logic [FET_COUNT-1:0] fet_oc_flag;
    logic oc_flag, oc_hold, oc_report;
    logic [CNT_W-1:0] oc_retry;
    logic oc_hit;
    assign oc_hit = |oc_event && oc_mode != MODE_OFF;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fet_oc_flag <= '0;
            oc_flag <= 1'b0;
        end else if (oc_hit) begin
            fet_oc_flag <= fet_oc_flag | oc_event; // Set wins over clear
            oc_flag <= 1'b1;
        end else if (clear_alarms_cmd) begin
            fet_oc_flag <= '0;
            oc_flag <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oc_hold <= 1'b0;
            oc_report <= 1'b0;
            oc_retry <= '0;
        end else begin
            if (oc_hit && oc_mode == MODE_LATCH) oc_hold <= 1'b1;
            else if (oc_hit && oc_mode == MODE_RETRY) begin
                oc_hold <= 1'b1;
                oc_retry <= CNT_W'(RETRY_CYCLES);
            end else if (oc_retry != '0) begin
                oc_retry <= oc_retry - 1'b1;
                if (oc_retry == CNT_W'(1)) oc_hold <= 1'b0;
            end else if (clear_alarms_cmd && !(|oc_raw)) oc_hold <= 1'b0;
            if (oc_hit && oc_mode == MODE_REPORT) oc_report <= 1'b1;
            else if (clear_alarms_cmd && !(|oc_raw)) oc_report <= 1'b0;
        end
    end

    // Regulator overcurrent: deglitch then fixed retry, flags drop on expiry
    // A fault still present when the retry ends fires again at once
    logic [CNT_W-1:0] rg_cnt, rg_retry;
    logic rg_flag;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rg_cnt <= '0;
            rg_retry <= '0;
            rg_flag <= 1'b0;
        end else begin
            rg_cnt <= rg_raw ? (rg_cnt == CNT_W'(REG_DEG_CYCLES) ? rg_cnt : rg_cnt + 1'b1) : '0;
            if (rg_raw && rg_cnt == CNT_W'(REG_DEG_CYCLES) && rg_retry == '0) begin
                rg_flag <= 1'b1;
                rg_retry <= CNT_W'(RETRY_CYCLES);
            end else if (rg_retry != '0) begin
                rg_retry <= rg_retry - 1'b1;
                if (rg_retry == CNT_W'(1)) rg_flag <= 1'b0;
            end
        end
    end

    // Stall: count Hall silence in milliseconds against the programmed time
    logic [CNT_W-1:0] ms_div, stall_retry;
    logic [15:0] silent_ms, stall_limit;
    logic stall_event, stall_flag, stall_hold, stall_report;
    assign stall_limit = PIN_VARIANT ? 16'(STALL_FIXED_MS) : stall_time;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_div <= '0;
            silent_ms <= '0;
            stall_event <= 1'b0;
        end else begin
            stall_event <= 1'b0;
            if (hall_s2 != hall_prev || !fet_enable) begin
                ms_div <= '0;
                silent_ms <= '0;
            end else if (ms_div == CNT_W'(STALL_MS_CYCLES - 1)) begin
                ms_div <= '0;
                if (silent_ms == stall_limit) begin
                    silent_ms <= '0;
                    stall_event <= stall_mode != MODE_OFF;
                end else silent_ms <= silent_ms + 16'h0001;
            end else ms_div <= ms_div + 1'b1;
        end
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stall_flag <= 1'b0;
            stall_hold <= 1'b0;
            stall_report <= 1'b0;
            stall_retry <= '0;
        end else begin
            if (stall_event) begin
                stall_flag <= 1'b1;
                stall_hold <= stall_mode != MODE_REPORT;
                stall_report <= stall_mode == MODE_REPORT;
                if (stall_mode == MODE_RETRY) stall_retry <= CNT_W'(STALL_RETRY_CYCLES);
            end else if (stall_retry != '0) begin
                stall_retry <= stall_retry - 1'b1;
                if (stall_retry == CNT_W'(1)) begin
                    stall_hold <= 1'b0;
                    stall_flag <= 1'b0;
                end
            end else if (clear_alarms_cmd) begin
                stall_flag <= 1'b0;
                stall_hold <= 1'b0;
                stall_report <= 1'b0;
            end
        end
    end

    // Overvoltage and thermal flags
    logic ov_now, ov_flag, warn_flag, warn_alarm, shut_flag;
    assign ov_now = ov_en && volts > ov_thresh;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ov_flag <= 1'b0;
            warn_flag <= 1'b0;
            warn_alarm <= 1'b0;
            shut_flag <= 1'b0;
        end else begin
            if (ov_now) ov_flag <= 1'b1;
            else if (clear_alarms_cmd) ov_flag <= 1'b0;
            if (warn_raw) warn_flag <= 1'b1;
            else if (clear_alarms_cmd) warn_flag <= 1'b0;
            if (warn_raw && thermal_warning_report_en) warn_alarm <= 1'b1;
            else if (hys_s2) warn_alarm <= 1'b0;
            if (shut_raw) shut_flag <= 1'b1;
            else if (clear_alarms_cmd) shut_flag <= 1'b0;
        end
    end

    // Outputs: all registered, alarm is the sum of reported conditions
    logic any_alarm_flag, thermal_summary_flag;
    assign thermal_summary_flag = warn_flag || shut_flag;
    // Summary follows the latched flags, so it drops with the regulator and stall flags when their retries expire
    assign any_alarm_flag = ov_flag || oc_flag || rg_flag || stall_flag || shut_flag;
    // Report-only overcurrent must not touch the FETs, so oc_hit gates them
    // only in the protective modes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_out_n <= 1'b1;
            fet_enable <= 1'b0;
            reg_fet_enable <= 1'b0;
            charge_pump_enable <= 1'b0;
        end else begin
            alarm_out_n <= !(ov_now || oc_hold || oc_report || rg_flag || stall_hold
                             || stall_report || warn_alarm || shut_raw);
            fet_enable <= !(ov_now || oc_hold || stall_hold || shut_raw
                            || (oc_hit && oc_mode != MODE_REPORT));
            reg_fet_enable <= !rg_flag;
            charge_pump_enable <= !shut_raw;
        end
    end

    // Register read: data valid in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) reg_rdata <= '0;
        else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CONFIG: reg_rdata <= config_reg;
                ADDR_CHIP_STATUS: reg_rdata <= {11'h000, shut_flag, rg_flag, thermal_summary_flag,
                                                ov_flag, any_alarm_flag};
                ADDR_FAULT_STATUS: reg_rdata <= {6'h00, rg_flag, stall_flag, warn_flag, oc_flag, fet_oc_flag};
                ADDR_STALL_TIME: reg_rdata <= stall_time;
                default: reg_rdata <= '0;
            endcase
        end
    end

    // Assertions
    // Each one looks one edge after its trigger, since every output is registered
    sequence retry_run_s;
        oc_hit && oc_mode == MODE_RETRY;
    endsequence
    report_keeps_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        oc_hit && oc_mode == MODE_REPORT && !(ov_now || oc_hold || stall_hold || shut_raw)
        |=> fet_enable) else $error("report mode stopped FETs");
    ov_alarm_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ov_now |=> !alarm_out_n && !fet_enable && ov_flag) else $error("overvoltage not acted on");
    oc_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        oc_mode == MODE_OFF && !oc_flag |=> !oc_flag || $past(oc_hit)) else $error("disabled overcurrent flagged");
    retry_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        retry_run_s |=> oc_hold && oc_flag) else $error("retry did not stop FETs");
    shut_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        shut_raw |=> !fet_enable && !charge_pump_enable && shut_flag) else $error("shutdown not applied");
    warn_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        warn_raw && !thermal_warning_report_en && !warn_alarm |=> warn_flag && !warn_alarm) else $error("warning misreported");
    ov_sticky_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ov_flag && !clear_alarms_cmd |=> ov_flag) else $error("overvoltage flag dropped");
    rg_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(rg_flag) |=> !reg_fet_enable) else $error("regulator FETs not disabled");
endmodule
`default_nettype wire

// ---- host_partner.sv ----
// Host-side model: spins the Hall sensors and gives sleep-pin reset pulses.
// Assumes the fault manager samples these pins on ref_clk.
`default_nettype none
module host_partner (
    input  wire logic       ref_clk,
    input  wire logic       hall_run,
    output var  logic [2:0] hall_in,
    output var  logic       sleep_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned tick = 0;
    initial begin
        hall_in     = 3'h1;
        sleep_pin_n = 1'b1;
    end
    // Hall edge every 4 cycles, well inside the stall time
    always @(posedge ref_clk) begin
        if (hall_run) begin
            tick <= tick + 1;
            if (tick % 4 == 3) hall_in <= {hall_in[1:0], hall_in[2]};
        end
    end
    // Short low pulse, far under the 400-cycle sleep limit
    task automatic reset_pulse();
        @(posedge ref_clk) sleep_pin_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        sleep_pin_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- motor_driver_fault_manager_test.sv ----
// Self-checking bench for the fault manager, driven over its strobe port.
// Assumes shortened retry and stall parameters, set below.
`default_nettype none
module motor_driver_fault_manager_test;
    import fault_manager_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, sys_rst = 1, reg_over_current = 0, reg_wr = 0, reg_rd = 0, hall_run = 1;
    logic temp_over_warn = 0, temp_below_hys = 1, temp_over_shutdown = 0, sleep_pin_n;
    logic [5:0] supply_volts = 6'h0A, fet_over_lvl = 6'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
    logic [2:0] hall_in;
    logic alarm_out_n, fet_enable, reg_fet_enable, charge_pump_enable;
    logic [1:0] oc_level_sel;
    int bad_count = 0, num_checks = 0, cycles = 0;
    motor_driver_fault_manager #(.RETRY_CYCLES(20), .STALL_RETRY_CYCLES(30), .STALL_MS_CYCLES(2)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .supply_volts(supply_volts), .fet_over_lvl(fet_over_lvl),
        .reg_over_current(reg_over_current), .hall_in(hall_in), .temp_over_warn(temp_over_warn),
        .temp_below_hys(temp_below_hys), .temp_over_shutdown(temp_over_shutdown), .sleep_pin_n(sleep_pin_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .alarm_out_n(alarm_out_n), .fet_enable(fet_enable), .reg_fet_enable(reg_fet_enable),
        .charge_pump_enable(charge_pump_enable), .oc_level_sel(oc_level_sel));
    host_partner partner (.ref_clk(ref_clk), .hall_run(hall_run), .hall_in(hall_in), .sleep_pin_n(sleep_pin_n));
    // 10 MHz clock
    initial forever #50 ref_clk = ~ref_clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard, far above the expected run length
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        #1 num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk) begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
        end
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    // Read data stand from the cycle after the strobe until the next read strobe
    task automatic cr(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk) begin
            reg_addr <= a;
            reg_rd <= 1'b1;
        end
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 rv = reg_rdata;
        chk_reg(rv, exp);
    endtask
    task automatic clr();
        wr(ADDR_CONTROL, 16'h0001);
        cyc(4);
    endtask
    task automatic oc_pulse(input int n);
        @(posedge ref_clk) fet_over_lvl <= 6'h01;
        cyc(n);
        fet_over_lvl <= 6'h00;
    endtask
    task automatic stall(input logic [15:0] cfg, input logic fe, input logic al, input logic [15:0] st);
        wr(ADDR_CONFIG, cfg);
        hall_run <= 1'b0;
        cyc(30);
        chk_pin(fet_enable, fe);
        chk_pin(alarm_out_n, al);
        cr(ADDR_FAULT_STATUS, st);
        hall_run <= 1'b1;
    endtask
    initial begin
        cyc(2);
        sys_rst <= 1'b0;
        cr(ADDR_CONFIG, CONFIG_RESET);
        cr(ADDR_STALL_TIME, 16'h03E8);
        cr(4'hF, 16'h0000);
        // Overvoltage: disabled, high and low thresholds
        supply_volts <= 6'h21;
        cyc(8);
        chk_pin(alarm_out_n, 1'b1);
        wr(ADDR_CONFIG, 16'h0003);
        cyc(8);
        chk_pin(alarm_out_n, 1'b0);
        supply_volts <= 6'h1E;
        cyc(8);
        chk_pin(alarm_out_n, 1'b1);
        clr();
        wr(ADDR_CONFIG, 16'h0001);
        supply_volts <= 6'h15;
        cyc(8);
        chk_pin(fet_enable, 1'b0);
        chk_pin(alarm_out_n, 1'b0);
        cr(ADDR_CHIP_STATUS, 16'h0003);
        supply_volts <= 6'h0A;
        cyc(8);
        chk_pin(fet_enable, 1'b1);
        chk_pin(alarm_out_n, 1'b1);
        cr(ADDR_CHIP_STATUS, 16'h0003);
        clr();
        cr(ADDR_CHIP_STATUS, 16'h0000);
        // Overcurrent in every mode
        wr(ADDR_CONFIG, 16'h0000);
        oc_pulse(3);
        cyc(8);
        cr(ADDR_FAULT_STATUS, 16'h0000);
        oc_pulse(12);
        cyc(8);
        chk_pin(fet_enable, 1'b0);
        chk_pin(alarm_out_n, 1'b0);
        cr(ADDR_FAULT_STATUS, 16'h0041);
        clr();
        chk_pin(fet_enable, 1'b1);
        wr(ADDR_CONFIG, 16'h0004);
        oc_pulse(12);
        cyc(5);
        chk_pin(fet_enable, 1'b0);
        cyc(35);
        chk_pin(fet_enable, 1'b1);
        chk_pin(alarm_out_n, 1'b1);
        cr(ADDR_FAULT_STATUS, 16'h0041);
        clr();
        wr(ADDR_CONFIG, 16'h0008);
        oc_pulse(12);
        chk_pin(fet_enable, 1'b1);
        cyc(40);
        chk_pin(fet_enable, 1'b1);
        chk_pin(alarm_out_n, 1'b0);
        clr();
        chk_pin(alarm_out_n, 1'b1);
        wr(ADDR_CONFIG, 16'h000C);
        oc_pulse(12);
        cyc(8);
        chk_pin(alarm_out_n, 1'b1);
        cr(ADDR_FAULT_STATUS, 16'h0000);
        wr(ADDR_CONFIG, 16'h0680);
        oc_pulse(9);
        cyc(8);
        chk_pin(oc_level_sel == 2'h3, 1'b1);
        cr(ADDR_FAULT_STATUS, 16'h0000);
        // Regulator overcurrent retries and its flags drop
        @(posedge ref_clk) reg_over_current <= 1'b1;
        cyc(15);
        reg_over_current <= 1'b0;
        chk_pin(reg_fet_enable, 1'b0);
        cr(ADDR_CHIP_STATUS, 16'h0009);
        cyc(40);
        chk_pin(reg_fet_enable, 1'b1);
        cr(ADDR_CHIP_STATUS, 16'h0000);
        // Thermal warning, unreported then reported
        wr(ADDR_CONFIG, 16'h0000);
        temp_over_warn <= 1'b1;
        cyc(8);
        chk_pin(alarm_out_n, 1'b1);
        chk_pin(fet_enable, 1'b1);
        cr(ADDR_FAULT_STATUS, 16'h0080);
        clr();
        cr(ADDR_FAULT_STATUS, 16'h0080);
        wr(ADDR_CONFIG, 16'h0040);
        temp_below_hys <= 1'b0;
        cyc(8);
        chk_pin(alarm_out_n, 1'b0);
        temp_over_warn <= 1'b0;
        temp_below_hys <= 1'b1;
        cyc(8);
        chk_pin(alarm_out_n, 1'b1);
        clr();
        cr(ADDR_FAULT_STATUS, 16'h0000);
        // Thermal shutdown
        wr(ADDR_CONFIG, 16'h000C);
        temp_over_shutdown <= 1'b1;
        cyc(8);
        chk_pin(charge_pump_enable, 1'b0);
        chk_pin(alarm_out_n, 1'b0);
        chk_pin(fet_enable, 1'b0);
        cr(ADDR_CHIP_STATUS, 16'h0015);
        temp_over_shutdown <= 1'b0;
        cyc(8);
        chk_pin(charge_pump_enable, 1'b1);
        cr(ADDR_CHIP_STATUS, 16'h0015);
        clr();
        // Stall with a 10-cycle detection time
        wr(ADDR_STALL_TIME, 16'h0004);
        stall(16'h0020, 1'b1, 1'b0, 16'h0100);
        partner.reset_pulse();
        cyc(8);
        chk_pin(alarm_out_n, 1'b1);
        stall(16'h0000, 1'b0, 1'b0, 16'h0100);
        cyc(20);
        chk_pin(fet_enable, 1'b0);
        clr();
        chk_pin(fet_enable, 1'b1);
        stall(16'h0010, 1'b0, 1'b0, 16'h0100);
        cyc(50);
        chk_pin(fet_enable, 1'b1);
        cr(ADDR_FAULT_STATUS, 16'h0000);
        stall(16'h0030, 1'b1, 1'b1, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
